/* File: irq_mode_pkg.sv */
// Package: register map, bit layout and timing constants of the interrupt and mode block
package irq_mode_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_EVENT    = 4'he;
  localparam logic [3:0] ADDR_OPMODE   = 4'hf;
  localparam logic [7:0] RESET_EVENT   = 8'h00;
  localparam logic [7:0] RESET_MASK    = 8'h00;
  localparam logic [7:0] RESET_OPMODE  = 8'h00;
  localparam int         EVENT_W       = 8;

  // ----------------------------------------------------------------
  // Event bit positions
  // ----------------------------------------------------------------
  localparam int BIT_TIMER    = 7;
  localparam int BIT_SIGFIFO  = 6;
  localparam int BIT_MONFIFO  = 5;
  localparam int BIT_MONACT   = 4;
  localparam int BIT_FRAMING  = 3;
  localparam int BIT_MISMATCH = 2;
  localparam int BIT_SYNCWIN  = 1;
  localparam int BIT_SYNCOVF  = 0;

  // ----------------------------------------------------------------
  // Operation mode bit positions and codes
  // ----------------------------------------------------------------
  localparam int BIT_MODE_HI    = 7;
  localparam int BIT_MODE_LO    = 6;
  localparam int BIT_PCM_SB     = 5;
  localparam int BIT_PCM_TL     = 4;
  localparam int BIT_CFI_DRV    = 3;
  localparam int BIT_MON_PROTO  = 2;
  localparam int BIT_CFI_SB     = 1;
  localparam int BIT_BANK       = 0;

  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_TEST  = 2'h1;
  localparam logic [1:0] MODE_INIT  = 2'h2;
  localparam logic [1:0] MODE_NORM  = 2'h3;
  localparam logic [7:0] CMD_CM_RESET = 8'h70;
  localparam logic [3:0] CODE_UNASSIGNED = 4'h0;

  // ----------------------------------------------------------------
  // Access durations in reference clock cycles, times ten
  // ----------------------------------------------------------------
  localparam int T_RESET_X10 = 2560;
  localparam int T_INIT_X10  = 25;
  localparam int T_NORM_X10  = 95;
  localparam int T_TRI_X10   = 10350;
  localparam int T_TEST_X10  = 20570;
  // Each time rounds down, at least one cycle
  localparam int CYC_RESET   = (T_RESET_X10 / 10 < 1) ? 1 : T_RESET_X10 / 10;
  localparam int CYC_INIT    = (T_INIT_X10 / 10 < 1) ? 1 : T_INIT_X10 / 10;
  localparam int CYC_NORM    = (T_NORM_X10 / 10 < 1) ? 1 : T_NORM_X10 / 10;
  localparam int CYC_TRI     = (T_TRI_X10 / 10 < 1) ? 1 : T_TRI_X10 / 10;
  localparam int CYC_TEST    = (T_TEST_X10 / 10 < 1) ? 1 : T_TEST_X10 / 10;
  localparam int CNT_W       = 12;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic timer_expire;
    logic sigfifo_nonempty;
    logic monfifo_done;
    logic monitor_found;
    logic pcm_sync_status;
    logic mismatch_detect;
    logic sync_window_open;
    logic sync_window_miss;
  } event_src_t;

  typedef struct packed {
    logic       start;
    logic       tristate_init;
    logic [7:0] command;
    logic [7:0] data;
  } mem_req_t;
endpackage : irq_mode_pkg

/* File: access_timer.sv */
// Access timer: counts out one control memory access of given length
`timescale 1ns/1ps
`default_nettype none
module access_timer #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  // Control
  input  wire logic             start_i,
  input  wire logic [CNT_W-1:0] length_i,
  // Status
  output logic                  busy_o,
  output logic                  done_o
);
  logic [CNT_W-1:0] count_reg;

  // Down counter loaded on start, done pulses in the cycle after the last busy cycle
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_reg <= '0;
      busy_o    <= 1'b0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        count_reg <= length_i;
        busy_o    <= 1'b1;
      end else if (busy_o) begin
        if (count_reg <= CNT_W'(1)) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
        count_reg <= count_reg - CNT_W'(1);
      end
    end
  end
endmodule // access_timer
`default_nettype wire

/* File: irq_mode_ctrl.sv */
// Interrupt status, mask and operation mode logic of the switching controller
`timescale 1ns/1ps
`default_nettype none
// Function
// - Timer flag in bit 7 sets on each expiry with interrupt enabled, clears on read.
// - Timer events repeat every expiry until timer value register is written.
// - Signaling FIFO flag follows FIFO non-empty; status read does not clear it.
// - Monitor FIFO flag sets on command completion, clears on status read.
// - Monitor active flag sets when search finds channel, clears on read.
// - Framing flag sets on any sync status change, clears on read.
// - Mismatch flag sets on detect, clears on read, rearms after detail read.
// - Sync window flag sets on window open only with a channel enabled.
// - Sync overflow flag sets when window missed, clears on read.
// - Mask bit one suppresses interrupt for same status bit.
// - Masked events are held and shown once the mask clears.
// - Signaling FIFO flag shows while masked but raises no interrupt.
// - Mask write with unmasked event pending drops interrupt briefly.
// - Mode 00 clears all control memory within 256 cycles; interfaces off.
// - Reset command 70 hex writes data value and code 0000 everywhere.
// - Mode 10 accesses take at most 2.5 reference cycles, no switching.
// - Mode 11 interfaces run; access 9 cycles, tristate init 1035.
// - Monitor protocol bit enables the handshake facility when one.
// - PCM standby zero floats transmit pins, tristate controls high.
// - PCM test loop loops transmit to receive, ignores external receive.
// - CFI standby zero floats CFI data, clock and frame outputs.
module irq_mode_ctrl #(
  parameter int CNT_W = irq_mode_pkg::CNT_W
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    sys_rst_i,
  // Register port
  input  wire logic [3:0]              reg_addr_i,
  input  wire logic                    reg_rd_i,
  input  wire logic                    reg_wr_i,
  input  wire logic [7:0]              reg_wdata_i,
  output logic      [7:0]              reg_rdata_o,
  // Event sources, same clock domain
  input  wire irq_mode_pkg::event_src_t evt_i,
  input  wire logic                    timer_irq_en_i,
  input  wire logic                    timer_value_wr_i,
  input  wire logic                    mismatch_detail_rd_i,
  input  wire logic                    sync_chan_en_i,
  // Memory access request
  input  wire irq_mode_pkg::mem_req_t  mem_req_i,
  // Interrupt and mode outputs
  output logic                         irq_o,
  output logic      [1:0]              mode_o,
  output logic                         normal_switching_o,
  output logic                         all_locations_o,
  output logic                         handshake_en_o,
  output logic                         pcm_tx_oe_o,
  output logic                         pcm_tsc_inactive_o,
  output logic                         pcm_loop_o,
  output logic                         cfi_oe_o,
  output logic                         cfi_open_drain_o,
  output logic                         bank_sel_o,
  output logic                         mem_busy_o,
  output logic                         mem_done_o,
  output logic      [7:0]              mem_fill_data_o,
  output logic      [3:0]              mem_fill_code_o
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int EW = irq_mode_pkg::EVENT_W;

  typedef enum logic [2:0] {
    ACC_IDLE = 3'b001,
    ACC_RUN  = 3'b010,
    ACC_DONE = 3'b100
  } acc_state_t;

  logic [EW-1:0]  event_reg;
  logic [EW-1:0]  mask_reg;
  logic [7:0]     opmode_reg;
  logic [EW-1:0]  set_vec;
  logic [EW-1:0]  visible;
  logic [EW-1:0]  clr_vec;
  logic           status_rd;
  logic           mask_wr;
  logic           pss_reg;
  logic           timer_armed_reg;
  logic           mismatch_armed_reg;
  logic           irq_drop_reg;
  logic [1:0]     mode;
  logic           mode_run;
  logic [CNT_W-1:0] acc_len;
  logic           acc_busy;
  logic           acc_done;
  logic           acc_start;
  acc_state_t     acc_state_reg;

  assign status_rd = reg_rd_i && (reg_addr_i == irq_mode_pkg::ADDR_EVENT);
  assign mask_wr   = reg_wr_i && (reg_addr_i == irq_mode_pkg::ADDR_EVENT);
  assign mode      = opmode_reg[irq_mode_pkg::BIT_MODE_HI:irq_mode_pkg::BIT_MODE_LO];
  // Interfaces run in modes 01 and 11
  assign mode_run  = opmode_reg[irq_mode_pkg::BIT_MODE_LO];

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  // Timer interrupt armed by start with enable, disarmed by value write
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer_armed_reg <= 1'b0;
    end else if (timer_value_wr_i) begin
      timer_armed_reg <= 1'b0;
    end else if (timer_irq_en_i) begin
      timer_armed_reg <= 1'b1;
    end
  end

  // Previous sync status for edge detection
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pss_reg <= 1'b0;
    end else begin
      pss_reg <= evt_i.pcm_sync_status;
    end
  end

  // Mismatch rearm: blocked after set until detail register read
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mismatch_armed_reg <= 1'b1;
    end else if (mismatch_detail_rd_i) begin
      mismatch_armed_reg <= 1'b1;
    end else if (set_vec[irq_mode_pkg::BIT_MISMATCH]) begin
      mismatch_armed_reg <= 1'b0;
    end
  end

  // Set conditions per event bit
  always_comb begin
    set_vec = '0;
    set_vec[irq_mode_pkg::BIT_TIMER]    = evt_i.timer_expire && timer_armed_reg;
    set_vec[irq_mode_pkg::BIT_MONFIFO]  = evt_i.monfifo_done;
    set_vec[irq_mode_pkg::BIT_MONACT]   = evt_i.monitor_found;
    set_vec[irq_mode_pkg::BIT_FRAMING]  = evt_i.pcm_sync_status ^ pss_reg;
    set_vec[irq_mode_pkg::BIT_MISMATCH] = evt_i.mismatch_detect && mismatch_armed_reg;
    set_vec[irq_mode_pkg::BIT_SYNCWIN]  = evt_i.sync_window_open && sync_chan_en_i;
    set_vec[irq_mode_pkg::BIT_SYNCOVF]  = evt_i.sync_window_miss && sync_chan_en_i;
  end

  // Status visible only where unmasked; FIFO flag always visible
  always_comb begin
    visible = event_reg & ~mask_reg;
    visible[irq_mode_pkg::BIT_SIGFIFO] = event_reg[irq_mode_pkg::BIT_SIGFIFO];
  end

  // Read clears only the bits that were returned
  assign clr_vec = status_rd ? visible : '0;

  // Sticky flags, one per bit except the signaling FIFO level bit; set wins over clear
  generate
    for (genvar i = 0; i < EW; i++) begin : g_flag
      if (i == irq_mode_pkg::BIT_SIGFIFO) begin : g_level
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
          if (sys_rst_i) begin
            event_reg[i] <= irq_mode_pkg::RESET_EVENT[i];
          end else begin
            event_reg[i] <= evt_i.sigfifo_nonempty;
          end
        end
      end else begin : g_sticky
        always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
          if (sys_rst_i) begin
            event_reg[i] <= irq_mode_pkg::RESET_EVENT[i];
          end else if (set_vec[i]) begin
            event_reg[i] <= 1'b1;
          end else if (clr_vec[i]) begin
            event_reg[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Mask register, write only
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mask_reg <= irq_mode_pkg::RESET_MASK;
    end else if (mask_wr) begin
      mask_reg <= reg_wdata_i;
    end
  end

  // Operation mode register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      opmode_reg <= irq_mode_pkg::RESET_OPMODE;
    end else if (reg_wr_i && (reg_addr_i == irq_mode_pkg::ADDR_OPMODE)) begin
      opmode_reg <= reg_wdata_i;
    end
  end

  // Registered read data; unmapped reads return zero
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        irq_mode_pkg::ADDR_EVENT:  reg_rdata_o <= visible;
        irq_mode_pkg::ADDR_OPMODE: reg_rdata_o <= opmode_reg;
        default:                   reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt request
  // ----------------------------------------------------------------
  // Drop held a second cycle after a mask write while an unmasked event pends
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_drop_reg <= 1'b0;
    end else begin
      irq_drop_reg <= mask_wr && |(event_reg & ~mask_reg);
    end
  end

  // Request from unmasked flags, forced low during drop
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      irq_o <= 1'b0;
    end else if (mask_wr || irq_drop_reg) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(event_reg & ~mask_reg);
    end
  end

  // ----------------------------------------------------------------
  // Operation mode outputs
  // ----------------------------------------------------------------
  // Interface and protocol controls from the mode register
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mode_o             <= irq_mode_pkg::MODE_RESET;
      normal_switching_o <= 1'b0;
      all_locations_o    <= 1'b0;
      handshake_en_o     <= 1'b0;
      pcm_tx_oe_o        <= 1'b0;
      pcm_tsc_inactive_o <= 1'b1;
      pcm_loop_o         <= 1'b0;
      cfi_oe_o           <= 1'b0;
      cfi_open_drain_o   <= 1'b0;
      bank_sel_o         <= 1'b0;
    end else begin
      mode_o             <= mode;
      normal_switching_o <= mode_run;
      all_locations_o    <= (mode == irq_mode_pkg::MODE_TEST);
      handshake_en_o     <= opmode_reg[irq_mode_pkg::BIT_MON_PROTO];
      pcm_tx_oe_o        <= opmode_reg[irq_mode_pkg::BIT_PCM_SB] && mode_run;
      pcm_tsc_inactive_o <= !(opmode_reg[irq_mode_pkg::BIT_PCM_SB] && mode_run);
      pcm_loop_o         <= opmode_reg[irq_mode_pkg::BIT_PCM_TL];
      cfi_oe_o           <= opmode_reg[irq_mode_pkg::BIT_CFI_SB] && mode_run;
      cfi_open_drain_o   <= opmode_reg[irq_mode_pkg::BIT_CFI_DRV];
      bank_sel_o         <= opmode_reg[irq_mode_pkg::BIT_BANK];
    end
  end

  // ----------------------------------------------------------------
  // Memory access timing
  // ----------------------------------------------------------------
  // Access length per mode
  always_comb begin
    unique case (mode)
      irq_mode_pkg::MODE_RESET: acc_len = CNT_W'(irq_mode_pkg::CYC_RESET);
      irq_mode_pkg::MODE_INIT:  acc_len = CNT_W'(irq_mode_pkg::CYC_INIT);
      irq_mode_pkg::MODE_NORM:  acc_len = mem_req_i.tristate_init ?
                                          CNT_W'(irq_mode_pkg::CYC_TRI) :
                                          CNT_W'(irq_mode_pkg::CYC_NORM);
      irq_mode_pkg::MODE_TEST:  acc_len = CNT_W'(irq_mode_pkg::CYC_TEST);
    endcase
  end

  assign acc_start = mem_req_i.start && (acc_state_reg == ACC_IDLE);

  access_timer #(.CNT_W(CNT_W)) u_access_timer (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .start_i   (acc_start),
    .length_i  (acc_len),
    .busy_o    (acc_busy),
    .done_o    (acc_done)
  );

  // Access sequencing
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      acc_state_reg <= ACC_IDLE;
    end else begin
      unique case (acc_state_reg)
        ACC_IDLE: if (acc_start) acc_state_reg <= ACC_RUN;
        ACC_RUN:  if (acc_done) acc_state_reg <= ACC_DONE;
        ACC_DONE: acc_state_reg <= ACC_IDLE;
        default:  acc_state_reg <= ACC_IDLE;
      endcase
    end
  end

  // Fill values for the reset command
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mem_busy_o      <= 1'b0;
      mem_done_o      <= 1'b0;
      mem_fill_data_o <= 8'h00;
      mem_fill_code_o <= irq_mode_pkg::CODE_UNASSIGNED;
    end else begin
      mem_busy_o <= acc_busy || acc_start;
      mem_done_o <= acc_done;
      if (acc_start && mode == irq_mode_pkg::MODE_RESET &&
          mem_req_i.command == irq_mode_pkg::CMD_CM_RESET) begin
        mem_fill_data_o <= mem_req_i.data;
        mem_fill_code_o <= irq_mode_pkg::CODE_UNASSIGNED;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_sticky_clear: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    status_rd && !set_vec[irq_mode_pkg::BIT_MONFIFO] && visible[irq_mode_pkg::BIT_MONFIFO]
    |=> !event_reg[irq_mode_pkg::BIT_MONFIFO])
    else $error("monitor fifo flag not cleared by read");
  a_set_wins: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    set_vec[irq_mode_pkg::BIT_TIMER] |=> event_reg[irq_mode_pkg::BIT_TIMER])
    else $error("timer event lost");
  a_fifo_follow: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    evt_i.sigfifo_nonempty |=> event_reg[irq_mode_pkg::BIT_SIGFIFO])
    else $error("signaling fifo flag not set");
  a_mismatch_block: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    set_vec[irq_mode_pkg::BIT_MISMATCH] ##1 !mismatch_detail_rd_i |=> !set_vec[irq_mode_pkg::BIT_MISMATCH])
    else $error("mismatch rearmed without detail read");
  a_frame_edge: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    $changed(evt_i.pcm_sync_status) |=> event_reg[irq_mode_pkg::BIT_FRAMING])
    else $error("framing change missed");
  a_irq_drop: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    mask_wr |=> !irq_o)
    else $error("interrupt not dropped on mask write");
  a_irq_masked: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !mask_wr && !irq_drop_reg && (event_reg & ~mask_reg) == '0 |=> !irq_o)
    else $error("interrupt raised by masked event");
  a_sync_gate: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !sync_chan_en_i && !event_reg[irq_mode_pkg::BIT_SYNCWIN]
    |=> !event_reg[irq_mode_pkg::BIT_SYNCWIN])
    else $error("sync window flag set with no channel");
  a_init_len: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    acc_start && mode == irq_mode_pkg::MODE_INIT |-> ##[1:3] acc_done)
    else $error("init access too slow");
  a_pcm_float: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    !opmode_reg[irq_mode_pkg::BIT_PCM_SB] |=> !pcm_tx_oe_o && pcm_tsc_inactive_o)
    else $error("pcm outputs driven in standby");
endmodule // irq_mode_ctrl
`default_nettype wire

/* File: irq_mode_ctrl_tb_top.sv */
// Testbench for the interrupt status, mask and operation mode block
`timescale 1ns/1ps
`default_nettype none
module irq_mode_ctrl_tb_top;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic                     clk_sys_i = 1'b0;
  logic                     sys_rst_i = 1'b1;
  logic [3:0]               reg_addr_i = 4'h0;
  logic                     reg_rd_i = 1'b0;
  logic                     reg_wr_i = 1'b0;
  logic [7:0]               reg_wdata_i = 8'h00;
  irq_mode_pkg::event_src_t evt = '0;
  logic                     ten = 1'b0;
  logic                     tvw = 1'b0;
  logic                     mdr = 1'b0;
  logic                     sce = 1'b0;
  irq_mode_pkg::mem_req_t   req = '0;
  logic [7:0]               rdata;
  logic [7:0]               fdata;
  logic [3:0]               fcode;
  logic                     irq, hs, poe, tsc, coe, done;
  logic [1:0]               mo;
  logic                     ns, al, lp, od, bk, busy;
  logic [7:0]               d;
  int                       errors = 0;
  int                       num_checks = 0;
  int                       cycles = 0;

  irq_mode_ctrl irq_mode_ctrl_inst (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(rdata), .evt_i(evt), .timer_irq_en_i(ten), .timer_value_wr_i(tvw),
    .mismatch_detail_rd_i(mdr), .sync_chan_en_i(sce), .mem_req_i(req), .irq_o(irq),
    .mode_o(mo), .normal_switching_o(ns), .all_locations_o(al), .handshake_en_o(hs),
    .pcm_tx_oe_o(poe), .pcm_tsc_inactive_o(tsc), .pcm_loop_o(lp), .cfi_oe_o(coe),
    .cfi_open_drain_o(od), .bank_sel_o(bk), .mem_busy_o(busy), .mem_done_o(done),
    .mem_fill_data_o(fdata), .mem_fill_code_o(fcode));

  // Clock and hang guard
  initial forever #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = rdata;
  endtask
  // One-cycle pulse on the chosen event sources
  task automatic ev(input logic [7:0] v);
    @(posedge clk_sys_i);
    evt <= irq_mode_pkg::event_src_t'(evt | v);
    @(posedge clk_sys_i);
    evt <= irq_mode_pkg::event_src_t'(evt & ~v);
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_timer();
    @(posedge clk_sys_i) ten <= 1'b1;
    @(posedge clk_sys_i) ten <= 1'b0;
    ev(8'h80);
    chk("irq", 8'h01, {7'h00, irq});
    rd(4'he); chk("status", 8'h80, d);
    rd(4'he); chk("status", 8'h00, d);
    ev(8'h80); rd(4'he); chk("status", 8'h80, d);
    @(posedge clk_sys_i) tvw <= 1'b1;
    @(posedge clk_sys_i) tvw <= 1'b0;
    ev(8'h80); rd(4'he); chk("status", 8'h00, d);
  endtask
  task automatic t_mask();
    @(posedge clk_sys_i) ten <= 1'b1;
    @(posedge clk_sys_i) ten <= 1'b0;
    wr(4'he, 8'h80); ev(8'h80);
    chk("irq", 8'h00, {7'h00, irq});
    rd(4'he); chk("status", 8'h00, d);
    wr(4'he, 8'h00); chk("irq", 8'h01, {7'h00, irq});
    rd(4'he); chk("status", 8'h80, d);
    @(posedge clk_sys_i) tvw <= 1'b1;
    @(posedge clk_sys_i) tvw <= 1'b0;
    rd(4'h0); chk("unmapped", 8'h00, d);
  endtask
  task automatic t_sig();
    wr(4'he, 8'h40);
    @(posedge clk_sys_i) evt.sigfifo_nonempty <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1 chk("irq", 8'h00, {7'h00, irq});
    rd(4'he); chk("status", 8'h40, d);
    rd(4'he); chk("status", 8'h40, d);
    @(posedge clk_sys_i) evt.sigfifo_nonempty <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rd(4'he); chk("status", 8'h00, d);
    wr(4'he, 8'h00);
  endtask
  task automatic t_events();
    ev(8'h04); rd(4'he); chk("status", 8'h04, d);
    ev(8'h04); rd(4'he); chk("status", 8'h00, d);
    @(posedge clk_sys_i) mdr <= 1'b1;
    @(posedge clk_sys_i) mdr <= 1'b0;
    ev(8'h04); rd(4'he); chk("status", 8'h04, d);
    ev(8'h08); rd(4'he); chk("status", 8'h08, d);
    ev(8'h20); rd(4'he); chk("status", 8'h20, d);
    ev(8'h10); rd(4'he); chk("status", 8'h10, d);
    ev(8'h02); rd(4'he); chk("status", 8'h00, d);
    @(posedge clk_sys_i) sce <= 1'b1;
    ev(8'h02); rd(4'he); chk("status", 8'h02, d);
    ev(8'h01); rd(4'he); chk("status", 8'h01, d);
  endtask
  task automatic t_mode();
    wr(4'hf, 8'he6); rd(4'hf); chk("mode reg", 8'he6, d);
    chk("pins", 8'h0b, {4'h0, poe, tsc, coe, hs});
    chk("mode outs", 8'he0, {mo, ns, al, lp, od, bk, 1'b0});
    wr(4'hf, 8'h5d);
    chk("pins", 8'h05, {4'h0, poe, tsc, coe, hs});
    chk("mode outs", 8'h7e, {mo, ns, al, lp, od, bk, 1'b0});
    wr(4'hf, 8'ha2);
    chk("pins", 8'h04, {4'h0, poe, tsc, coe, hs});
    chk("mode outs", 8'h80, {mo, ns, al, lp, od, bk, 1'b0});
    wr(4'hf, 8'hc0);
    chk("pins", 8'h04, {4'h0, poe, tsc, coe, hs});
  endtask
  task automatic t_mem(input logic [1:0] m, input int n, input logic [7:0] c, input logic t);
    int cnt;
    cnt = 0;
    wr(4'hf, {m, 6'h00});
    @(posedge clk_sys_i) req <= '{1'b1, t, c, 8'h5a};
    @(posedge clk_sys_i) req.start <= 1'b0;
    #1 chk("busy", 8'h01, {7'h00, busy});
    while (done !== 1'b1 && cnt < n + 10) begin
      @(posedge clk_sys_i);
      #1 cnt++;
    end
    chk("access time", 8'h01, {7'h00, cnt >= n && cnt <= n + 2});
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1 chk("tsc", 8'h01, {7'h00, tsc});
    rd(4'he); chk("status", 8'h00, d);
    rd(4'hf); chk("mode reg", 8'h00, d);
    t_timer();
    t_mask();
    t_sig();
    t_events();
    t_mode();
    t_mem(irq_mode_pkg::MODE_RESET, 256, irq_mode_pkg::CMD_CM_RESET, 1'b0);
    chk("fill data", 8'h5a, fdata);
    chk("fill code", 8'h00, {4'h0, fcode});
    t_mem(irq_mode_pkg::MODE_INIT, 2, 8'h00, 1'b0);
    t_mem(irq_mode_pkg::MODE_NORM, 9, 8'h00, 1'b0);
    t_mem(irq_mode_pkg::MODE_NORM, 1035, 8'h00, 1'b1);
    t_mem(irq_mode_pkg::MODE_TEST, 2057, 8'h00, 1'b0);
    stop_test();
  end
endmodule // irq_mode_ctrl_tb_top
`default_nettype wire
